/* verilog/pcs_pkg.sv */
// shared constants and carrier types for the program-flow and indirect-access block
package pcs_pkg;

  // widths
  localparam int PC_W        = 13;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 8;
  localparam int EA_W        = 9;
  localparam int HIGH_W      = 5;
  localparam int TARGET_W    = 11;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;

  // register offsets on the software port
  localparam logic [ADDR_W-1:0] REG_INDIRECT = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PC_LOW   = 8'h02;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h03;
  localparam logic [ADDR_W-1:0] REG_SEL_PTR  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PC_HIGH  = 8'h0A;

  // field positions
  localparam int BANK_BIT_POS  = 7;
  localparam int PAGE_HI_POS   = 4;
  localparam int PAGE_LO_POS   = 3;
  localparam int LOW_BYTE_HI   = 7;
  localparam int UPPER_LO_POS  = 8;

  // reset and step values
  localparam logic [PC_W-1:0]        PC_RESET    = 13'h0000;
  localparam logic [PC_W-1:0]        PC_STEP     = 13'h0001;
  localparam logic [PC_W-1:0]        IRQ_VECTOR  = 13'h0004;
  localparam logic [HIGH_W-1:0]      LATCH_RESET = 5'h00;
  localparam logic [DATA_W-1:0]      BYTE_ZERO   = 8'h00;
  localparam logic [STACK_PTR_W-1:0] PTR_STEP    = 3'h1;

  // where the next counter value comes from
  typedef enum logic [2:0] {
    PC_HOLD,
    PC_NEXT_SEQ,
    PC_LOW_WRITE,
    PC_BRANCH,
    PC_POP,
    PC_VECTOR
  } pc_src_e;

  // one instruction-level command from the execution logic
  typedef struct packed {
    logic                fetch;
    logic                jump;
    logic                call;
    logic                ret_plain;
    logic                ret_literal;
    logic                ret_interrupt;
    logic                irq_branch;
    logic [TARGET_W-1:0] target;
  } exec_cmd_s;

  // software register request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  // data memory write port
  typedef struct packed {
    logic              wr;
    logic [EA_W-1:0]   addr;
    logic [DATA_W-1:0] wdata;
  } mem_wr_s;

endpackage

/* verilog/return_stack.sv */
// circular return-address stack held in flip-flops
`timescale 1ns/100ps
`default_nettype none

module return_stack (
  // clock and reset
  input  wire logic                             clk_i,
  input  wire logic                             nrst_i,
  // push and pop
  input  wire logic                             push_i,
  input  wire logic                             pop_i,
  input  wire logic [pcs_pkg::PC_W-1:0]         push_data_i,
  output logic      [pcs_pkg::PC_W-1:0]         top_o,
  output logic                                  wrap_o
);

  typedef struct packed {
    logic [pcs_pkg::STACK_DEPTH-1:0][pcs_pkg::PC_W-1:0] entry;
    logic [pcs_pkg::STACK_PTR_W-1:0]                    ptr;
    logic                                               wrap;
  } stack_state_s;

  stack_state_s state_reg;
  stack_state_s state_next;

  // pointer is internal only: no path to the software port, see R8
  always_comb begin
    state_next = state_reg;
    if (push_i) begin
      // a full stack simply overwrites the oldest slot, see R12
      state_next.entry[state_reg.ptr] = push_data_i;
      state_next.ptr                  = state_reg.ptr + pcs_pkg::PTR_STEP;
      if (state_reg.ptr == '1) begin
        state_next.wrap = 1'b1;
      end
    end else if (pop_i) begin
      state_next.ptr = state_reg.ptr - pcs_pkg::PTR_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // top entry is the slot just below the pointer, see R10
  assign top_o  = state_reg.entry[state_reg.ptr - pcs_pkg::PTR_STEP];
  assign wrap_o = state_reg.wrap;

endmodule

`default_nettype wire

/* verilog/indirect_access.sv */
// indirect data port: effective address, self-select guard, posted write
`timescale 1ns/100ps
`default_nettype none

module indirect_access (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // access through the indirect data port
  input  wire logic                          rd_i,
  input  wire logic                          wr_i,
  input  wire logic [pcs_pkg::DATA_W-1:0]    wdata_i,
  // pointer and bank
  input  wire logic [pcs_pkg::DATA_W-1:0]    sel_ptr_i,
  input  wire logic                          bank_i,
  // data memory
  input  wire logic [pcs_pkg::DATA_W-1:0]    mem_rdata_i,
  output pcs_pkg::mem_wr_s                   mem_wr_o,
  output logic      [pcs_pkg::DATA_W-1:0]    rdata_o
);

  typedef struct packed {
    pcs_pkg::mem_wr_s post;
  } ind_state_s;

  ind_state_s                   state_reg;
  ind_state_s                   state_next;
  logic [pcs_pkg::EA_W-1:0]     eff_addr;
  logic                         self_sel;

  // bank bit sits above the pointer, see R16
  assign eff_addr = {bank_i, sel_ptr_i};
  assign self_sel = (sel_ptr_i == pcs_pkg::REG_INDIRECT);

  // write is posted one cycle so memory sees a registered strobe
  always_comb begin
    state_next            = state_reg;
    state_next.post.wr    = 1'b0;
    if (wr_i && !self_sel) begin
      // pointer at the port itself stores nothing, see R15
      state_next.post.wr    = 1'b1;
      state_next.post.addr  = eff_addr;
      state_next.post.wdata = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // bypass covers a read right behind a posted write to the same place
  always_comb begin
    rdata_o = mem_rdata_i; // see R13
    if (!rd_i || self_sel) begin
      rdata_o = pcs_pkg::BYTE_ZERO; // see R14
    end else if (state_reg.post.wr && state_reg.post.addr == eff_addr) begin
      rdata_o = state_reg.post.wdata;
    end
  end

  assign mem_wr_o = state_reg.post;

endmodule

`default_nettype wire

/* verilog/program_flow.sv */
// program counter, high latch, return stack and indirect addressing
//
// Contract
// R1: 13-bit counter, low byte software read/write.
// R2: upper five bits never software visible.
// R3: any reset clears the whole counter.
// R4: low-byte write loads upper bits from latch.
// R5: call or jump takes top bits from latch.
// R6: software carries into latch on table rollover.
// R7: eight-entry, thirteen-bit return stack.
// R8: stack and pointer hidden from software.
// R9: push counter on call or interrupt branch.
// R10: pop on any of three returns.
// R11: push and pop leave latch untouched.
// R12: stack wraps, overwriting oldest entry.
// R13: indirect port accesses pointer-selected location.
// R14: self-selected indirect read returns zero.
// R15: self-selected indirect write stores nothing.
// R16: nine-bit address: bank bit above pointer.
// R17: call or jump low eleven bits from operand.
// R18: otherwise counter steps by one per fetch.
`timescale 1ns/100ps
`default_nettype none

module program_flow (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // software register port
  input  wire logic [pcs_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [pcs_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [pcs_pkg::DATA_W-1:0]    reg_rdata_o,
  // commands from instruction execution
  input  wire pcs_pkg::exec_cmd_s            cmd_i,
  // program counter towards fetch
  output logic      [pcs_pkg::PC_W-1:0]      pc_o,
  output logic                               stack_wrap_o,
  // data memory for indirect access
  output logic      [pcs_pkg::EA_W-1:0]      mem_raddr_o,
  input  wire logic [pcs_pkg::DATA_W-1:0]    mem_rdata_i,
  output pcs_pkg::mem_wr_s                   mem_wr_o
);

  // all state of this level
  typedef struct packed {
    logic [pcs_pkg::PC_W-1:0]   pc;
    logic [pcs_pkg::HIGH_W-1:0] latch;
    logic [pcs_pkg::DATA_W-1:0] sel_ptr;
    logic                       bank;
    logic [pcs_pkg::DATA_W-1:0] rdata;
  } flow_state_s;

  flow_state_s                  state_reg;
  flow_state_s                  state_next;

  pcs_pkg::reg_req_s            req;
  pcs_pkg::pc_src_e             pc_src;

  // decoded register hits
  logic                         hit_indirect;
  logic                         hit_pc_low;
  logic                         hit_status;
  logic                         hit_sel_ptr;
  logic                         hit_pc_high;

  // command digest
  logic                         any_return;
  logic                         any_branch;
  logic                         do_push;
  logic                         do_pop;
  logic                         pc_low_wr;

  // values fed to the counter
  logic [pcs_pkg::PC_W-1:0]     pc_seq;
  logic [pcs_pkg::PC_W-1:0]     pc_branch;
  logic [pcs_pkg::PC_W-1:0]     pc_low_load;
  logic [pcs_pkg::PC_W-1:0]     stack_top;
  logic                         stack_wrap;

  // indirect unit link
  logic [pcs_pkg::DATA_W-1:0]   ind_rdata;
  logic                         ind_rd;
  logic                         ind_wr;
  logic [pcs_pkg::DATA_W-1:0]   rd_mux;

  assign req.wr    = reg_wr_i;
  assign req.rd    = reg_rd_i;
  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;

  // ---- address decode ----
  assign hit_indirect = (req.addr == pcs_pkg::REG_INDIRECT);
  assign hit_pc_low   = (req.addr == pcs_pkg::REG_PC_LOW);
  assign hit_status   = (req.addr == pcs_pkg::REG_STATUS);
  assign hit_sel_ptr  = (req.addr == pcs_pkg::REG_SEL_PTR);
  assign hit_pc_high  = (req.addr == pcs_pkg::REG_PC_HIGH);

  assign ind_rd = req.rd && hit_indirect;
  assign ind_wr = req.wr && hit_indirect;

  // ---- command digest ----
  // all three return flavours behave alike here, see R10
  assign any_return = cmd_i.ret_plain || cmd_i.ret_literal || cmd_i.ret_interrupt;
  assign any_branch = cmd_i.jump || cmd_i.call;

  // the write that targets the counter low byte
  assign pc_low_wr = req.wr && hit_pc_low;

  // only one stack action per cycle; an interrupt branch beats a return
  assign do_push = cmd_i.irq_branch || (!any_return && cmd_i.call); // see R9
  assign do_pop  = !cmd_i.irq_branch && any_return; // see R10

  // ---- candidate counter values ----
  // wraps at the 13-bit boundary, as the hardware counter does
  assign pc_seq = state_reg.pc + pcs_pkg::PC_STEP; // see R18

  // top two bits from the latch, eleven from the operand, see R5
  assign pc_branch = {state_reg.latch[pcs_pkg::PAGE_HI_POS:pcs_pkg::PAGE_LO_POS],
                      cmd_i.target}; // see R17

  // the low byte alone never carries into the latch, see R6
  assign pc_low_load = {state_reg.latch, req.wdata}; // see R4

  // ---- counter source selection ----
  // priority: interrupt branch, return, call or jump, low-byte write, fetch
  always_comb begin
    pc_src = pcs_pkg::PC_HOLD;
    if (cmd_i.irq_branch) begin
      pc_src = pcs_pkg::PC_VECTOR;
    end else if (any_return) begin
      pc_src = pcs_pkg::PC_POP;
    end else if (any_branch) begin
      pc_src = pcs_pkg::PC_BRANCH;
    end else if (pc_low_wr) begin
      pc_src = pcs_pkg::PC_LOW_WRITE;
    end else if (cmd_i.fetch) begin
      pc_src = pcs_pkg::PC_NEXT_SEQ;
    end
  end

  // ---- read data mux ----
  // unmapped offsets and reserved bits read as zero
  always_comb begin
    rd_mux = pcs_pkg::BYTE_ZERO;
    if (hit_indirect) begin
      rd_mux = ind_rdata; // see R13
    end else if (hit_pc_low) begin
      rd_mux = state_reg.pc[pcs_pkg::LOW_BYTE_HI:0]; // see R1
    end else if (hit_status) begin
      rd_mux[pcs_pkg::BANK_BIT_POS] = state_reg.bank;
    end else if (hit_sel_ptr) begin
      rd_mux = state_reg.sel_ptr;
    end else if (hit_pc_high) begin
      // this shows the latch, not the live upper counter bits, see R2
      rd_mux[pcs_pkg::HIGH_W-1:0] = state_reg.latch;
    end
  end

  // ---- next state ----
  always_comb begin
    state_next = state_reg;

    // read data stands only in the cycle after the strobe
    state_next.rdata = req.rd ? rd_mux : pcs_pkg::BYTE_ZERO;

    // latch is touched only by software writes, never by stack use, see R11
    if (req.wr && hit_pc_high) begin
      state_next.latch = req.wdata[pcs_pkg::HIGH_W-1:0];
    end
    if (req.wr && hit_sel_ptr) begin
      state_next.sel_ptr = req.wdata;
    end
    if (req.wr && hit_status) begin
      state_next.bank = req.wdata[pcs_pkg::BANK_BIT_POS]; // see R16
    end

    // upper counter bits change only through latch-based loads, pops, the vector and fetch carries, never by direct write, see R2
    unique case (pc_src)
      pcs_pkg::PC_HOLD:      state_next.pc = state_reg.pc;
      pcs_pkg::PC_NEXT_SEQ:  state_next.pc = pc_seq; // see R18
      pcs_pkg::PC_LOW_WRITE: state_next.pc = pc_low_load; // see R4
      pcs_pkg::PC_BRANCH:    state_next.pc = pc_branch; // see R5
      pcs_pkg::PC_POP:       state_next.pc = stack_top; // see R10
      pcs_pkg::PC_VECTOR:    state_next.pc = pcs_pkg::IRQ_VECTOR;
      default:               state_next.pc = state_reg.pc;
    endcase
  end

  // ---- state register ----
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg       <= '0;
      state_reg.pc    <= pcs_pkg::PC_RESET; // see R3
      state_reg.latch <= pcs_pkg::LATCH_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---- return stack ----
  // the current counter is already the return address
  return_stack u_stack (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .push_i      (do_push),
    .pop_i       (do_pop),
    .push_data_i (state_reg.pc),
    .top_o       (stack_top),
    .wrap_o      (stack_wrap)
  ); // see R7

  // ---- indirect data port ----
  indirect_access u_indirect (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .rd_i        (ind_rd),
    .wr_i        (ind_wr),
    .wdata_i     (req.wdata),
    .sel_ptr_i   (state_reg.sel_ptr),
    .bank_i      (state_reg.bank),
    .mem_rdata_i (mem_rdata_i),
    .mem_wr_o    (mem_wr_o),
    .rdata_o     (ind_rdata)
  );

  // ---- outputs, all from flip-flops ----
  assign pc_o         = state_reg.pc;
  assign reg_rdata_o  = state_reg.rdata;
  assign stack_wrap_o = stack_wrap;
  assign mem_raddr_o  = {state_reg.bank, state_reg.sel_ptr}; // see R16

endmodule

`default_nettype wire

/* dv/pcs_checker_assertions.sv */
// concurrent checks on the program-flow block ports
`timescale 1ns/100ps
`default_nettype none

module pcs_checker (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  nrst_i,
  // register port
  input wire logic [7:0]            reg_addr_i,
  input wire logic [7:0]            reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [7:0]            reg_rdata_o,
  // commands and counter
  input wire pcs_pkg::exec_cmd_s    cmd_i,
  input wire logic [12:0]           pc_o,
  input wire logic                  stack_wrap_o,
  // data memory
  input wire logic [8:0]            mem_raddr_o,
  input wire logic [7:0]            mem_rdata_i,
  input wire pcs_pkg::mem_wr_s      mem_wr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic ret_any;
  logic ind_hit;
  logic self_sel;
  logic br;
  assign ret_any  = cmd_i.ret_plain | cmd_i.ret_literal | cmd_i.ret_interrupt;
  assign ind_hit  = reg_addr_i == pcs_pkg::REG_INDIRECT;
  assign self_sel = mem_raddr_o[7:0] == pcs_pkg::BYTE_ZERO;
  assign br       = (cmd_i.call | cmd_i.jump) & !ret_any & !cmd_i.irq_branch;
  sequence call_s;
    cmd_i.call && !ret_any && !cmd_i.irq_branch;
  endsequence
  sequence ret_s;
    cmd_i.ret_plain && !cmd_i.irq_branch;
  endsequence
  reset_clear_a: assert property ($rose(nrst_i) |-> pc_o == pcs_pkg::PC_RESET)
    else $error("counter not cleared");
  fetch_step_a: assert property (cmd_i.fetch && !br && !ret_any && !cmd_i.irq_branch
    && !reg_wr_i |=> pc_o == $past(pc_o) + pcs_pkg::PC_STEP)
    else $error("counter did not step");
  branch_low_a: assert property (br |=> pc_o[10:0] == $past(cmd_i.target))
    else $error("branch operand not loaded");
  low_write_a: assert property (reg_wr_i && reg_addr_i == pcs_pkg::REG_PC_LOW && !br
    && !ret_any && !cmd_i.irq_branch |=> pc_o[7:0] == $past(reg_wdata_i))
    else $error("low byte write lost");
  irq_vector_a: assert property (cmd_i.irq_branch |=> pc_o == pcs_pkg::IRQ_VECTOR)
    else $error("interrupt branch wrong");
  call_ret_a: assert property (call_s ##1 ret_s |=> pc_o == $past(pc_o, 2))
    else $error("return address wrong");
  ind_write_a: assert property (reg_wr_i && ind_hit && !self_sel |=> mem_wr_o.wr
    && mem_wr_o.addr == $past(mem_raddr_o) && mem_wr_o.wdata == $past(reg_wdata_i))
    else $error("indirect write wrong");
  self_write_a: assert property (reg_wr_i && ind_hit && self_sel |=> !mem_wr_o.wr)
    else $error("self-selected write stored");
  self_read_a: assert property (reg_rd_i && ind_hit && self_sel |=> reg_rdata_o == 8'h00)
    else $error("self-selected read not zero");
  ind_read_a: assert property (reg_rd_i && ind_hit && !self_sel && !mem_wr_o.wr
    |=> reg_rdata_o == $past(mem_rdata_i))
    else $error("indirect read wrong");
endmodule

bind program_flow pcs_checker i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_i), .pc_o(pc_o),
  .stack_wrap_o(stack_wrap_o), .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i),
  .mem_wr_o(mem_wr_o));
`default_nettype wire

/* dv/data_mem_model.sv */
// data memory beside the block, answering indirect reads at once
`timescale 1ns/100ps
`default_nettype none

module data_mem_model (
  // clock
  input  wire logic              clk_i,
  // read and write ports
  input  wire logic [8:0]        raddr_i,
  input  wire pcs_pkg::mem_wr_s  wr_i,
  output logic      [7:0]        rdata_o
);
  logic [7:0] mem [0:511];
  // known fill so reads are predictable without prior writes
  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
  end
  assign rdata_o = mem[raddr_i];
  always @(posedge clk_i) begin
    if (wr_i.wr) begin
      mem[wr_i.addr] <= wr_i.wdata;
    end
  end
endmodule
`default_nettype wire

/* dv/program_flow_tb.sv */
// self-checking bench for the program-flow and indirect-access block
`timescale 1ns/100ps
`default_nettype none

module program_flow_tb;
  localparam int K_IRQ = 0, K_RTI = 1, K_CALL = 4, K_JMP = 5, K_FETCH = 6;
  logic clk_i, nrst_i, reg_wr_i, reg_rd_i, stack_wrap_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mem_rdata_i, rd_val;
  logic [12:0] pc_o;
  logic [8:0] mem_raddr_o;
  pcs_pkg::exec_cmd_s cmd_i;
  pcs_pkg::mem_wr_s mem_wr_o;
  int n_errors, cmp_count;

  program_flow i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cmd_i(cmd_i), .pc_o(pc_o), .stack_wrap_o(stack_wrap_o),
    .mem_raddr_o(mem_raddr_o), .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o));
  data_mem_model i_mem (.clk_i(clk_i), .raddr_i(mem_raddr_o), .wr_i(mem_wr_o),
    .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask

  task automatic do_cmd(input int k, input logic [10:0] t);
    pcs_pkg::exec_cmd_s c;
    c = '0;
    c[11 + k] = 1'b1;
    c.target = t;
    @(posedge clk_i);
    cmd_i <= c;
    @(posedge clk_i);
    cmd_i <= '0;
    #1;
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic t_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    check("pc after reset", pc_o, 16'h0000);
    check("wrap after reset", 16'(stack_wrap_o), 16'h0000);
    reg_rd(pcs_pkg::REG_PC_LOW);
    check("low byte after reset", rd_val, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_low();
    logic [12:0] tgt;
    // software carries the table offset into the latch itself
    tgt = 13'h02F0 + 13'h0020;
    reg_wr(pcs_pkg::REG_PC_HIGH, 8'(tgt[12:8]));
    reg_wr(pcs_pkg::REG_PC_LOW, tgt[7:0]);
    check("pc after low write", pc_o, 16'(tgt));
    reg_rd(pcs_pkg::REG_PC_LOW);
    check("low byte readback", rd_val, 16'(tgt[7:0]));
    reg_rd(8'h01);
    check("unmapped read", rd_val, 16'h0000);
    $display("low write test done");
  endtask

  task automatic t_branch();
    logic [12:0] pre;
    pcs_pkg::exec_cmd_s c;
    reg_wr(pcs_pkg::REG_PC_HIGH, 8'h18);
    do_cmd(K_JMP, 11'h7FF);
    check("jump page", pc_o, 16'h1FFF);
    // return right behind its call
    pre = pc_o;
    c = '0;
    c.call = 1'b1;
    c.target = 11'h123;
    @(posedge clk_i);
    cmd_i <= c;
    c = '0;
    c.ret_plain = 1'b1;
    @(posedge clk_i);
    cmd_i <= c;
    @(posedge clk_i);
    cmd_i <= '0;
    #1;
    check("quick return", pc_o, 16'(pre));
    do_cmd(K_FETCH, 11'h000);
    check("fetch wrap", pc_o, 16'h0000);
    pre = pc_o;
    do_cmd(K_IRQ, 11'h000);
    check("irq vector", pc_o, 16'(pcs_pkg::IRQ_VECTOR));
    do_cmd(K_RTI, 11'h000);
    check("irq return", pc_o, 16'(pre));
    $display("branch test done");
  endtask

  task automatic t_stack();
    logic [12:0] pushed [10];
    reg_wr(pcs_pkg::REG_PC_HIGH, 8'h15);
    for (int i = 0; i < 10; i++) begin
      pushed[i] = pc_o;
      do_cmd(K_CALL, 11'(16 * i + 64));
      check("call target", pc_o, 16'(13'h1000 + 16 * i + 64));
    end
    check("wrap flag", stack_wrap_o, 16'h0001);
    for (int j = 0; j < 8; j++) begin
      do_cmd(1 + j % 3, 11'h000);
      check("pop order", pc_o, 16'(pushed[9 - j]));
    end
    reg_rd(pcs_pkg::REG_PC_HIGH);
    check("latch kept", rd_val, 16'h0015);
    $display("stack test done");
  endtask

  task automatic t_ind();
    reg_wr(pcs_pkg::REG_STATUS, 8'hFF);
    reg_rd(pcs_pkg::REG_STATUS);
    check("status bank only", rd_val, 16'h0080);
    reg_wr(pcs_pkg::REG_SEL_PTR, 8'h20);
    reg_wr(pcs_pkg::REG_INDIRECT, 8'hA5);
    // posted write lands in memory one edge later
    @(posedge clk_i);
    #1;
    check("banked store", i_mem.mem[9'h120], 16'h00A5);
    reg_rd(pcs_pkg::REG_INDIRECT);
    check("banked load", rd_val, 16'h00A5);
    reg_wr(pcs_pkg::REG_STATUS, 8'h00);
    reg_rd(pcs_pkg::REG_INDIRECT);
    check("bank 0 load", rd_val, 16'(8'h20 ^ 8'h3C));
    reg_wr(pcs_pkg::REG_SEL_PTR, 8'h00);
    reg_rd(pcs_pkg::REG_INDIRECT);
    check("self read", rd_val, 16'h0000);
    reg_wr(pcs_pkg::REG_INDIRECT, 8'h77);
    @(posedge clk_i);
    #1;
    check("self write", i_mem.mem[9'h000], 16'h003C);
    $display("indirect test done");
  endtask

  initial begin
    n_errors = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    cmd_i = '0;
    t_reset();
    t_low();
    t_branch();
    t_stack();
    t_ind();
    t_reset();
    stop_test();
  end

  // guard against a hung run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
